// ---- rtl/occ_channel.sv ----
// output compare channel with avalon register slave and interrupt
`timescale 1ns/1ns
`include "occ_map.svh"
module occ_channel #(
  parameter int TW = 16
) (
  input  wire logic          sys_clk,
  input  wire logic          sys_rst,
  input  wire logic [4:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  input  wire logic [3:0]    avs_byteenable,
  output logic [31:0]        avs_readdata,
  output logic               avs_waitrequest,
  input  wire logic [TW-1:0] first_time_base,
  input  wire logic [TW-1:0] second_time_base,
  input  wire logic          cpu_idle,
  input  wire logic          fault_input_pin,
  output logic               compare_output_pin,
  output logic               compare_output_oe,
  output logic               irq
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  occ_pkg::occ_ctrl_s ctrl;
  occ_pkg::occ_ctrl_s next_ctrl;
  occ_pkg::occ_mode_e new_mode;
  logic [TW-1:0]      primary_compare_value;
  logic [TW-1:0]      next_primary_compare_value;
  logic [TW-1:0]      secondary_compare_value;
  logic [TW-1:0]      next_secondary_compare_value;
  logic [TW-1:0]      tmr;
  logic               pin;
  logic               next_pin;
  logic               oe;
  logic               next_oe;
  logic               done;
  logic               next_done;
  logic [1:0]         status;
  logic [1:0]         next_status;
  logic [1:0]         mask;
  logic [1:0]         next_mask;
  logic [1:0]         events;
  logic               next_irq;
  logic               wreq;
  logic               next_wreq;
  logic [31:0]        rdata;
  logic [31:0]        next_rdata;
  logic               flt_s1;
  logic               flt_s2;
  logic               flt_d;
  logic               flt_fall;
  logic               run;
  logic               pwm;
  logic               init;
  logic               acc_wr;
  logic               acc_rd;
  logic               hit_p;
  logic               hit_s;
  logic               boundary;

  // merge a 16-bit register with the two low byte lanes of a write
  function automatic logic [15:0] occ_merge(input logic [15:0] old_v,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
    logic [15:0] v;
    v = old_v;
    if (be[0])
      v[7:0] = wd[7:0];
    if (be[1])
      v[15:8] = wd[15:8];
    return v;
  endfunction

  // ------------------------------------------------------------
  // fault pin synchroniser
  // ------------------------------------------------------------
  // the pin is asynchronous; edge logic only looks at the second and third stages
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      flt_s1 <= 1'b1;
      flt_s2 <= 1'b1;
      flt_d  <= 1'b1;
    end
    else
    begin
      flt_s1 <= fault_input_pin;
      flt_s2 <= flt_s1;
      flt_d  <= flt_s2;
    end
  end

  // ------------------------------------------------------------
  // time base selection and match detection
  // ------------------------------------------------------------
  // halting in idle freezes both the detectors and the pin
  always_comb
  begin
    tmr      = ctrl.time_base_select ? second_time_base : first_time_base;
    run      = (ctrl.compare_mode_field != occ_pkg::OCC_OFF) &&
               !(ctrl.idle_halt_select && cpu_idle);
    pwm      = (ctrl.compare_mode_field == occ_pkg::OCC_PWM) ||
               (ctrl.compare_mode_field == occ_pkg::OCC_PWMF);
    flt_fall = flt_d && !flt_s2;
    acc_wr   = avs_write && !wreq;
    acc_rd   = avs_read && !wreq;
    new_mode = occ_pkg::occ_mode_e'(avs_writedata[`OCC_MODE_MSB:`OCC_MODE_LSB]);
    // the timer is assumed stopped by software around this write
    init     = acc_wr && (avs_address == `OCC_ADDR_CTRL) && avs_byteenable[0] &&
               (new_mode != ctrl.compare_mode_field);
  end

  // primary register match
  occ_match #(.TW(TW)) u_match_p (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .enable  (run),
    .count   (tmr),
    .compare (primary_compare_value),
    .hit     (hit_p)
  );

  // secondary register match, used by the pulse modes
  occ_match #(.TW(TW)) u_match_s (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .enable  (run),
    .count   (tmr),
    .compare (secondary_compare_value),
    .hit     (hit_s)
  );

  // the timer restarting at zero marks the pwm period boundary
  occ_match #(.TW(TW)) u_match_b (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .enable  (run),
    .count   (tmr),
    .compare (`OCC_ZERO16),
    .hit     (boundary)
  );

  // ------------------------------------------------------------
  // channel behaviour
  // ------------------------------------------------------------
  always_comb
  begin
    next_ctrl                    = ctrl;
    next_primary_compare_value   = primary_compare_value;
    next_secondary_compare_value = secondary_compare_value;
    next_pin                     = pin;
    next_done                    = done;
    next_mask                    = mask;
    events                       = 2'h0;
    if (acc_wr)
    begin
      case (avs_address)
        `OCC_ADDR_CTRL:
        begin
          // fault flag and unused bits are not writable
          if (avs_byteenable[1])
            next_ctrl.idle_halt_select = avs_writedata[`OCC_BIT_SIDL];
          if (avs_byteenable[0])
          begin
            next_ctrl.time_base_select   = avs_writedata[`OCC_BIT_TSEL];
            next_ctrl.compare_mode_field = new_mode;
          end
        end
        `OCC_ADDR_PRIM:
          next_primary_compare_value = occ_merge(primary_compare_value,
                                                 avs_writedata, avs_byteenable);
        `OCC_ADDR_SEC:
          next_secondary_compare_value = occ_merge(secondary_compare_value,
                                                   avs_writedata, avs_byteenable);
        `OCC_ADDR_MASK:
          if (avs_byteenable[0])
            next_mask = avs_writedata[1:0];
        default:
          next_mask = mask;
      endcase
    end
    if (init)
    begin
      // mode entry sets the starting level of the pin, except toggle and off, which keep the current level
      next_done = 1'b0;
      if (new_mode != occ_pkg::OCC_PWMF)
        next_ctrl.pwm_fault_flag = 1'b0;
      case (new_mode)
        occ_pkg::OCC_ONE_LO: next_pin = 1'b0;
        occ_pkg::OCC_ONE_HI: next_pin = 1'b1;
        occ_pkg::OCC_DELAY:  next_pin = 1'b0;
        occ_pkg::OCC_CONT:   next_pin = 1'b0;
        occ_pkg::OCC_PWM,
        occ_pkg::OCC_PWMF:   next_pin = (next_primary_compare_value != `OCC_ZERO16);
        default:             next_pin = pin;
      endcase
    end
    else if (run)
    begin
      case (ctrl.compare_mode_field)
        occ_pkg::OCC_ONE_LO:
          if (hit_p && !pin)
          begin
            next_pin  = 1'b1;
            events[0] = 1'b1;
          end
        occ_pkg::OCC_ONE_HI:
          if (hit_p && pin)
          begin
            next_pin  = 1'b0;
            events[0] = 1'b1;
          end
        occ_pkg::OCC_TOGGLE:
          if (hit_p)
          begin
            next_pin  = !pin;
            events[0] = 1'b1;
          end
        occ_pkg::OCC_DELAY,
        occ_pkg::OCC_CONT:
        begin
          // two registers: primary opens the pulse, secondary closes it
          if (hit_p && !done)
            next_pin = 1'b1;
          if (hit_s && (pin || next_pin))
          begin
            next_pin  = 1'b0;
            events[0] = pin;
            if (ctrl.compare_mode_field == occ_pkg::OCC_DELAY)
              next_done = 1'b1;
          end
        end
        occ_pkg::OCC_PWM,
        occ_pkg::OCC_PWMF:
        begin
          // duty taken over only on the boundary so a period never glitches
          if (boundary)
          begin
            next_primary_compare_value = secondary_compare_value;
            next_pin = (secondary_compare_value != `OCC_ZERO16);
          end
          else if (hit_p)
            next_pin = 1'b0;
          if (ctrl.compare_mode_field == occ_pkg::OCC_PWMF)
          begin
            // a latched fault clears at a boundary with the pin back high, or when another mode is written
            if (boundary && flt_s2 && ctrl.pwm_fault_flag)
              next_ctrl.pwm_fault_flag = 1'b0;
            if (flt_fall)
            begin
              next_ctrl.pwm_fault_flag = 1'b1;
              events[1] = 1'b1;
            end
            if (next_ctrl.pwm_fault_flag)
              next_pin = 1'b0;
          end
        end
        default:
          next_pin = pin;
      endcase
    end
    // a read of status clears it, but a new event in that cycle survives
    if (acc_rd && (avs_address == `OCC_ADDR_STATUS))
      next_status = events;
    else
      next_status = status | events;
    next_oe  = (next_ctrl.compare_mode_field != occ_pkg::OCC_OFF);
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ctrl                    <= occ_pkg::occ_ctrl_s'(`OCC_CTRL_RST);
      primary_compare_value   <= `OCC_CMP_RST;
      secondary_compare_value <= `OCC_CMP_RST;
      pin                     <= 1'b0;
      oe                      <= 1'b0;
      done                    <= 1'b0;
      status                  <= `OCC_IRQ_RST;
      mask                    <= `OCC_IRQ_RST;
      irq                     <= 1'b0;
    end
    else
    begin
      ctrl                    <= next_ctrl;
      primary_compare_value   <= next_primary_compare_value;
      secondary_compare_value <= next_secondary_compare_value;
      pin                     <= next_pin;
      oe                      <= next_oe;
      done                    <= next_done;
      status                  <= next_status;
      mask                    <= next_mask;
      irq                     <= next_irq;
    end
  end

  assign compare_output_pin = pin;
  assign compare_output_oe  = oe;

  // ------------------------------------------------------------
  // avalon slave: every access takes exactly one wait cycle
  // ------------------------------------------------------------
  always_comb
  begin
    next_wreq  = !((avs_read || avs_write) && wreq);
    next_rdata = rdata;
    if (avs_read && wreq)
    begin
      next_rdata = `OCC_RDATA_RST;
      case (avs_address)
        `OCC_ADDR_CTRL:
        begin
          // unused positions stay zero
          next_rdata[`OCC_BIT_SIDL] = ctrl.idle_halt_select;
          next_rdata[`OCC_BIT_FLT]  = ctrl.pwm_fault_flag;
          next_rdata[`OCC_BIT_TSEL] = ctrl.time_base_select;
          next_rdata[`OCC_MODE_MSB:`OCC_MODE_LSB] = ctrl.compare_mode_field;
        end
        `OCC_ADDR_PRIM:   next_rdata[15:0] = primary_compare_value;
        `OCC_ADDR_SEC:    next_rdata[15:0] = secondary_compare_value;
        // report events of this cycle too, since the clearing edge drops them
        `OCC_ADDR_STATUS: next_rdata[1:0]  = status | events;
        `OCC_ADDR_MASK:   next_rdata[1:0]  = mask;
        default:          next_rdata = `OCC_RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      wreq  <= 1'b1;
      rdata <= `OCC_RDATA_RST;
    end
    else
    begin
      wreq  <= next_wreq;
      rdata <= next_rdata;
    end
  end

  assign avs_waitrequest = wreq;
  assign avs_readdata    = rdata;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_step;
    run && !init;
  endsequence

  sequence s_fault_hit;
    s_step ##0 (ctrl.compare_mode_field == occ_pkg::OCC_PWMF) ##0 flt_fall;
  endsequence

  sequence s_pulse_end;
    s_step ##0 hit_s && pin && !hit_p;
  endsequence

  property p_disabled;
    (ctrl.compare_mode_field == occ_pkg::OCC_OFF) |-> !oe && (events == 2'h0);
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled channel drives pin");

  // a match on the first timer must never be seen while the second timer is selected
  property p_time_base;
    s_step ##0 ctrl.time_base_select ##0 (first_time_base == primary_compare_value)
      ##0 (second_time_base != primary_compare_value) |-> !hit_p;
  endproperty
  a_time_base: assert property (p_time_base) else $error("wrong time base");

  property p_one_lo;
    s_step ##0 (ctrl.compare_mode_field == occ_pkg::OCC_ONE_LO) ##0 hit_p && !pin
      |=> pin && status[`OCC_ST_EDGE];
  endproperty
  a_one_lo: assert property (p_one_lo) else $error("one-shot high missed");

  property p_one_hi;
    s_step ##0 (ctrl.compare_mode_field == occ_pkg::OCC_ONE_HI) ##0 hit_p && pin
      |=> !pin && status[`OCC_ST_EDGE];
  endproperty
  a_one_hi: assert property (p_one_hi) else $error("one-shot low missed");

  property p_toggle;
    s_step ##0 (ctrl.compare_mode_field == occ_pkg::OCC_TOGGLE) ##0 hit_p
      |=> (pin != $past(pin)) && status[`OCC_ST_EDGE];
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle missed");

  property p_delay_end;
    s_pulse_end ##0 (ctrl.compare_mode_field == occ_pkg::OCC_DELAY)
      |=> !pin && done ##1 !pin;
  endproperty
  a_delay_end: assert property (p_delay_end) else $error("single pulse not ended");

  property p_cont_end;
    s_pulse_end ##0 (ctrl.compare_mode_field == occ_pkg::OCC_CONT)
      |=> !pin && !done && status[`OCC_ST_EDGE];
  endproperty
  a_cont_end: assert property (p_cont_end) else $error("pulse end missed");

  property p_pwm_quiet;
    (ctrl.compare_mode_field == occ_pkg::OCC_PWM) |-> (events == 2'h0);
  endproperty
  a_pwm_quiet: assert property (p_pwm_quiet) else $error("pwm raised event");

  property p_fault;
    s_fault_hit |=> ctrl.pwm_fault_flag && !pin && status[`OCC_ST_FAULT];
  endproperty
  a_fault: assert property (p_fault) else $error("fault not latched");

  property p_flag_mode;
    (ctrl.compare_mode_field != occ_pkg::OCC_PWMF) |-> !ctrl.pwm_fault_flag;
  endproperty
  a_flag_mode: assert property (p_flag_mode) else $error("fault flag outside 111");

  property p_idle;
    (ctrl.idle_halt_select && cpu_idle && !init) |=> $stable(pin);
  endproperty
  a_idle: assert property (p_idle) else $error("pin moved while halted");

  property p_ctrl_zero;
    (!wreq && avs_read && (avs_address == `OCC_ADDR_CTRL))
      |-> (rdata[15:14] == 2'h0) && (rdata[12:5] == 8'h00);
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("unused bits not zero");

  property p_reload;
    s_step ##0 pwm ##0 boundary
      |=> primary_compare_value == $past(secondary_compare_value);
  endproperty
  a_reload: assert property (p_reload) else $error("duty not reloaded");

endmodule

// ---- rtl/occ_map.svh ----
// register map, field positions and reset values of the compare channel
`ifndef OCC_MAP_SVH
`define OCC_MAP_SVH

// byte addresses on the register bus
`define OCC_ADDR_CTRL    5'h00
`define OCC_ADDR_PRIM    5'h04
`define OCC_ADDR_SEC     5'h08
`define OCC_ADDR_STATUS  5'h0C
`define OCC_ADDR_MASK    5'h10

// control register field positions
`define OCC_BIT_SIDL     13
`define OCC_BIT_FLT      4
`define OCC_BIT_TSEL     3
`define OCC_MODE_MSB     2
`define OCC_MODE_LSB     0

// status and mask bit positions
`define OCC_ST_EDGE      0
`define OCC_ST_FAULT     1

// reset values
`define OCC_CTRL_RST     6'h00
`define OCC_CMP_RST      16'h0000
`define OCC_IRQ_RST      2'h0
`define OCC_RDATA_RST    32'h0000_0000
`define OCC_ZERO16       16'h0000

`endif

// ---- rtl/occ_pkg.sv ----
// types shared by the compare channel files
package occ_pkg;

  typedef enum logic [2:0]
  {
    OCC_OFF    = 3'b000,
    OCC_ONE_LO = 3'b001,
    OCC_ONE_HI = 3'b010,
    OCC_TOGGLE = 3'b011,
    OCC_DELAY  = 3'b100,
    OCC_CONT   = 3'b101,
    OCC_PWM    = 3'b110,
    OCC_PWMF   = 3'b111
  } occ_mode_e;

  typedef struct packed
  {
    logic      idle_halt_select;
    logic      pwm_fault_flag;
    logic      time_base_select;
    occ_mode_e compare_mode_field;
  } occ_ctrl_s;

endpackage

// ---- rtl/occ_match.sv ----
// equality detector that pulses once when a counter reaches a value
`timescale 1ns/1ns
module occ_match #(
  parameter int TW = 16
) (
  input  wire logic          sys_clk,
  input  wire logic          sys_rst,
  input  wire logic          enable,
  input  wire logic [TW-1:0] count,
  input  wire logic [TW-1:0] compare,
  output logic               hit
);

  logic was_equal;
  logic next_was_equal;
  logic equal;

  // a stopped timer sits on the value for many cycles, so only the first one counts
  always_comb
  begin
    equal          = (count == compare);
    next_was_equal = enable ? equal : was_equal;
    hit            = enable && equal && !was_equal;
  end

  // history of equality, frozen while halted
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      was_equal <= 1'b0;
    else
      was_equal <= next_was_equal;
  end

endmodule

// ---- tb/occ_load.sv ----
// model of the external load hanging on the compare output pin
`timescale 1ns/1ns
module occ_load (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic drive,
  input  wire logic oe,
  output logic      level,
  output int        rises
);
  logic last;

  // -------------------------------------------------------------------
  // line level and edge count
  // -------------------------------------------------------------------
  // a released line falls to the pull-down, never keeps the last value
  assign level = oe ? drive : 1'b0;

  // counts rising edges so pulse trains can be judged after the fact
  always_ff @(posedge sys_clk)
  begin
    last  <= level;
    rises <= sys_rst ? 0 : rises + int'(level & ~last);
  end
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the output compare channel
`timescale 1ns/1ns
`include "occ_map.svh"
module testbench;
  logic        sys_clk         = 1'b0;
  logic        sys_rst         = 1'b1;
  logic [4:0]  avs_address     = 5'h00;
  logic        avs_read        = 1'b0;
  logic        avs_write       = 1'b0;
  logic [31:0] avs_writedata   = 32'h0000_0000;
  logic [3:0]  avs_byteenable  = 4'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [15:0] ta              = 16'hFFFF;
  logic [15:0] tb              = 16'hFFFF;
  logic        cpu_idle        = 1'b0;
  logic        fault_n         = 1'b1;
  logic        pin;
  logic        oe;
  logic        irq;
  logic        level;
  int          rises;
  int          r0;
  int          n_errors        = 0;
  int          check_count     = 0;
  logic [31:0] rd;

  // -------------------------------------------------------------------
  // clock, design and load
  // -------------------------------------------------------------------
  always #5 sys_clk = ~sys_clk;

  occ_channel #(.TW(16)) occ_channel_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .first_time_base(ta),
    .second_time_base(tb), .cpu_idle(cpu_idle), .fault_input_pin(fault_n),
    .compare_output_pin(pin), .compare_output_oe(oe), .irq(irq));

  occ_load occ_load_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .drive(pin), .oe(oe),
    .level(level), .rises(rises));

  // -------------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // one bus access; the request stands until the edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [4:0] addr, input logic [15:0] wd);
    int n;
    n = 0;
    avs_address    <= addr;
    avs_writedata  <= {16'h0000, wd};
    avs_byteenable <= 4'h3;
    avs_write      <= wr;
    avs_read       <= ~wr;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    if (n >= 20)
    begin
      n_errors++;
      test_done();
    end
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rdchk(input logic [4:0] addr, input logic [31:0] exp, input string what);
    bus(1'b0, addr, 16'h0000);
    check(what, rd, exp);
  endtask

  // software keeps the timers parked while the control register is written
  task automatic cfg(input logic [15:0] ctrl, input logic [15:0] p, input logic [15:0] s);
    bus(1'b1, `OCC_ADDR_PRIM, p);
    bus(1'b1, `OCC_ADDR_SEC, s);
    bus(1'b1, `OCC_ADDR_CTRL, ctrl);
    bus(1'b0, `OCC_ADDR_STATUS, 16'h0000);
  endtask

  // steps one timer through a range, then lets the pin settle
  task automatic run(input logic sel, input int lo, input int hi);
    for (int v = lo; v <= hi; v++)
    begin
      @(posedge sys_clk);
      if (sel)
        tb <= 16'(v);
      else
        ta <= 16'(v);
    end
    repeat (3) @(posedge sys_clk);
  endtask

  // -------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------
  task automatic t_regs();
    check("oe after reset", oe, 1'b0);
    bus(1'b1, `OCC_ADDR_MASK, 16'h0003);
    bus(1'b1, `OCC_ADDR_CTRL, 16'hFFF8);
    rdchk(`OCC_ADDR_CTRL, 32'h0000_2008, "ctrl");
    rdchk(5'h14, 32'h0000_0000, "unmapped");
    rdchk(`OCC_ADDR_MASK, 32'h0000_0003, "mask");
    run(1'b1, 0, 9);
    run(1'b0, 0, 9);
    check("oe off", oe, 1'b0);
    check("irq off", irq, 1'b0);
    rdchk(`OCC_ADDR_STATUS, 32'h0000_0000, "status off");
  endtask

  task automatic t_oneshot();
    cfg(16'h0009, 16'h0005, 16'h0000);
    check("start low", level, 1'b0);
    check("oe on", oe, 1'b1);
    run(1'b0, 0, 9);
    check("other timer", level, 1'b0);
    run(1'b1, 0, 9);
    check("forced high", level, 1'b1);
    check("irq rise", irq, 1'b1);
    rdchk(`OCC_ADDR_STATUS, 32'h0000_0001, "status rise");
    check("irq cleared", irq, 1'b0);
    cfg(16'h000A, 16'h0005, 16'h0000);
    check("start high", level, 1'b1);
    run(1'b1, 0, 9);
    check("forced low", level, 1'b0);
    rdchk(`OCC_ADDR_STATUS, 32'h0000_0001, "status fall");
  endtask

  task automatic t_toggle();
    cfg(16'h0003, 16'h0005, 16'h0000);
    check("level kept", level, 1'b0);
    run(1'b0, 0, 9);
    check("toggle up", level, 1'b1);
    rdchk(`OCC_ADDR_STATUS, 32'h0000_0001, "status up");
    bus(1'b1, `OCC_ADDR_CTRL, 16'h2003);
    cpu_idle <= 1'b1;
    run(1'b0, 0, 9);
    check("halted", level, 1'b1);
    rdchk(`OCC_ADDR_STATUS, 32'h0000_0000, "status halted");
    // with the halt bit clear the channel keeps running through idle
    bus(1'b1, `OCC_ADDR_CTRL, 16'h0003);
    run(1'b0, 0, 9);
    check("toggle down", level, 1'b0);
    rdchk(`OCC_ADDR_STATUS, 32'h0000_0001, "status down");
    cpu_idle <= 1'b0;
  endtask

  task automatic t_pulse();
    cfg(16'h0004, 16'h0003, 16'h0006);
    r0 = rises;
    check("delay start", level, 1'b0);
    run(1'b0, 0, 4);
    check("primary raises", level, 1'b1);
    run(1'b0, 5, 9);
    check("secondary lowers", level, 1'b0);
    rdchk(`OCC_ADDR_STATUS, 32'h0000_0001, "status single");
    run(1'b0, 0, 9);
    check("single pulse", 32'(rises - r0), 32'h0000_0001);
    cfg(16'h0005, 16'h0003, 16'h0006);
    r0 = rises;
    run(1'b0, 0, 9);
    run(1'b0, 0, 9);
    check("pulse train", 32'(rises - r0), 32'h0000_0002);
    check("train ends low", level, 1'b0);
    rdchk(`OCC_ADDR_STATUS, 32'h0000_0001, "status train");
  endtask

  task automatic t_pwm();
    cfg(16'h0006, 16'h0000, 16'h0004);
    check("pwm zero start", level, 1'b0);
    run(1'b0, 0, 2);
    check("pwm high", level, 1'b1);
    bus(1'b1, `OCC_ADDR_SEC, 16'h0001);
    run(1'b0, 3, 9);
    check("old duty held", level, 1'b0);
    rdchk(`OCC_ADDR_STATUS, 32'h0000_0000, "pwm no irq");
    bus(1'b1, `OCC_ADDR_CTRL, 16'h0000);
    bus(1'b1, `OCC_ADDR_CTRL, 16'h0006);
    check("pwm nonzero start", level, 1'b1);
  endtask

  task automatic t_fault();
    bus(1'b1, `OCC_ADDR_CTRL, 16'h0007);
    fault_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check("fault low", level, 1'b0);
    check("fault irq", irq, 1'b1);
    rdchk(`OCC_ADDR_CTRL, 32'h0000_0017, "fault flag");
    bus(1'b1, `OCC_ADDR_CTRL, 16'h0007);
    rdchk(`OCC_ADDR_CTRL, 32'h0000_0017, "flag kept");
    rdchk(`OCC_ADDR_STATUS, 32'h0000_0002, "status fault");
    check("fault irq cleared", irq, 1'b0);
    fault_n <= 1'b1;
    @(posedge sys_clk);
  endtask

  // -------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    t_regs();
    t_oneshot();
    t_toggle();
    t_pulse();
    t_pwm();
    t_fault();
    test_done();
  end
endmodule
